// ==== touch_cfg_pkg.sv ====
// Purpose: Shared constants and carriers for the touch sensor configuration register bank
// Assumes: 16-bit registers addressed by an 8-bit word address
// Notes:   Decoded fields travel to the sensing core as packed structs
package touch_cfg_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_LP_SETUP     = 8'h36;
   localparam logic [7:0] ADDR_LP_TX_SELECT = 8'h37;
   localparam logic [7:0] ADDR_TP_CONV_FREQ = 8'h3D;
   localparam logic [7:0] ADDR_LP_CONV_FREQ = 8'h3E;
   localparam logic [7:0] ADDR_TP_HW        = 8'h3F;
   localparam logic [7:0] ADDR_LP_HW        = 8'h40;
   localparam logic [7:0] ADDR_TP_SETTINGS  = 8'h41;

   // Writable bit masks; everything else reads as zero
   localparam logic [15:0] MASK_LP_SETUP     = 16'h03FF;
   localparam logic [15:0] MASK_LP_TX_SELECT = 16'h1FFF;
   localparam logic [15:0] MASK_CONV_FREQ    = 16'hFFFF;
   localparam logic [15:0] MASK_HW           = 16'hFFFF;
   localparam logic [15:0] MASK_TP_SETTINGS  = 16'hFF3F;

   // Reset values
   localparam logic [15:0] RST_LP_SETUP     = 16'h0000;
   localparam logic [15:0] RST_LP_TX_SELECT = 16'h0000;
   localparam logic [15:0] RST_CONV_FREQ    = 16'h7F01;
   localparam logic [15:0] RST_HW           = 16'h0000;
   localparam logic [15:0] RST_TP_SETTINGS  = 16'h0000;

   // Field positions
   localparam int LP_COUNT_FILTER_BIT = 9;
   localparam int LP_SENSE_METHOD_BIT = 8;
   localparam int HW_NOISE_STATIC_BIT = 15;
   localparam int HW_DISCHARGE_BIT    = 14;
   localparam int HW_RF_FILTER_BIT    = 13;
   localparam int HW_POOL_CAP_BIT     = 12;
   localparam int TP_MAV_BIT          = 5;
   localparam int TP_FIXED_DAMP_BIT   = 4;
   localparam int TP_IIR_BIT          = 3;
   localparam int TP_SWAP_BIT         = 2;
   localparam int TP_FLIP_Y_BIT       = 1;
   localparam int TP_FLIP_X_BIT       = 0;

   // Count limits by code
   localparam logic [14:0] COUNT_LIMIT_0 = 15'h03FF;
   localparam logic [14:0] COUNT_LIMIT_1 = 15'h07FF;
   localparam logic [14:0] COUNT_LIMIT_2 = 15'h0FFF;
   localparam logic [14:0] COUNT_LIMIT_3 = 15'h4000;

   // Initial delay cycles by code
   localparam logic [6:0] INIT_DELAY_0 = 7'h04;
   localparam logic [6:0] INIT_DELAY_1 = 7'h10;
   localparam logic [6:0] INIT_DELAY_2 = 7'h20;
   localparam logic [6:0] INIT_DELAY_3 = 7'h40;

   // Auto-proximity cycle base; code n gives base shifted left by n
   localparam logic [5:0] AUTOPROX_BASE = 6'h04;

   typedef enum logic {
      SENSE_SELF,
      SENSE_PROJECTED
   } sense_method_t;

   typedef struct packed {
      logic          count_filter_en;
      sense_method_t sense_method;
      logic [7:0]    rx_enable;
      logic [12:0]   tx_enable;
   } lowpower_channel_cfg_t;

   typedef struct packed {
      logic [7:0] fraction;
      logic [7:0] period;
   } conv_freq_t;

   typedef struct packed {
      logic        noise_mode_static;
      logic        sample_cap_discharge_level;
      logic        rf_filter_en;
      logic        pool_cap_large;
      logic [1:0]  opamp_bias;
      logic [14:0] count_limit;
      logic        deep_sleep_autoprox_en;
      logic [5:0]  deep_sleep_autoprox_cycles;
      logic        light_sleep_autoprox_en;
      logic [5:0]  light_sleep_autoprox_cycles;
      logic [6:0]  init_delay_cycles;
   } hw_cfg_t;

   typedef struct packed {
      logic [7:0] total_rx;
      logic       moving_average_filter;
      logic       fixed_damping_select;
      logic       iir_filter_en;
      logic       axis_swap;
      logic       flip_y;
      logic       flip_x;
   } trackpad_cfg_t;

endpackage

// ==== touch_sensor_config_regs.sv ====
// Purpose: Configuration register bank of the capacitive trackpad controller
// Assumes: Host reaches registers through a simple word-addressed port, one clock
// Notes:   Reads are registered; decoded settings go to the sensing core
//
// Operation
// - Count filter bit filters low-power channel count
// - Method bit selects self or projected sensing
// - Eight receive enables include electrodes in channel
// - Thirteen transmit enables; top three bits unused
// - Upper byte holds frequency fraction
// - Lower byte holds conversion period
// - Noise mode static bit enables feature
// - Discharge bit selects 0V or 0.5V
// - Filter bit enables internal RF filters
// - Pool capacitor bit picks 40pF or 80pF
// - Two-bit code selects conversion count limit
// - Deep sleep autoprox cycles; top bit disables
// - Light sleep autoprox cycles; top bit disables
// - Two-bit code selects initial delay cycles
// - Trackpad upper byte gives receive total
// - Moving average filter bit on position
// - Static bit fixes damping, else dynamic
// - Recursive filter applies only while enabled
// - Swap bit exchanges receive and transmit axes
// - Flip bits invert reported X and Y
// - Fraction 127 period table gives frequencies
`timescale 1ns/1ps
module touch_sensor_config_regs (
   input  wire logic                                  clock,
   input  wire logic                                  rst,
   input  wire logic                                  reg_write,
   input  wire logic                                  reg_read,
   input  wire logic [7:0]                            reg_addr,
   input  wire logic [15:0]                           reg_wdata,
   output logic      [15:0]                           reg_rdata,
   output logic                                       reg_rvalid,
   output touch_cfg_pkg::lowpower_channel_cfg_t       lowpower_cfg,
   output touch_cfg_pkg::conv_freq_t                  trackpad_conv_freq,
   output touch_cfg_pkg::conv_freq_t                  lowpower_conv_freq,
   output touch_cfg_pkg::hw_cfg_t                     trackpad_hw_cfg,
   output touch_cfg_pkg::hw_cfg_t                     lowpower_hw_cfg,
   output touch_cfg_pkg::trackpad_cfg_t               trackpad_cfg
);

   logic [15:0] lowpower_channel_setup;
   logic [15:0] lowpower_channel_tx_select;
   logic [15:0] trackpad_conversion_frequency;
   logic [15:0] lowpower_conversion_frequency;
   logic [15:0] trackpad_hardware_settings;
   logic [15:0] lowpower_hardware_settings;
   logic [15:0] trackpad_settings;
   logic [15:0] next_rdata;

   // Count limit per code
   function automatic logic [14:0] count_limit_of(input logic [1:0] code);
      case (code)
         2'h0:    count_limit_of = touch_cfg_pkg::COUNT_LIMIT_0;
         2'h1:    count_limit_of = touch_cfg_pkg::COUNT_LIMIT_1;
         2'h2:    count_limit_of = touch_cfg_pkg::COUNT_LIMIT_2;
         default: count_limit_of = touch_cfg_pkg::COUNT_LIMIT_3;
      endcase
   endfunction

   // Initial delay per code
   function automatic logic [6:0] init_delay_of(input logic [1:0] code);
      case (code)
         2'h0:    init_delay_of = touch_cfg_pkg::INIT_DELAY_0;
         2'h1:    init_delay_of = touch_cfg_pkg::INIT_DELAY_1;
         2'h2:    init_delay_of = touch_cfg_pkg::INIT_DELAY_2;
         default: init_delay_of = touch_cfg_pkg::INIT_DELAY_3;
      endcase
   endfunction

   // Decode one hardware settings word; shared by trackpad and low-power copies
   function automatic touch_cfg_pkg::hw_cfg_t decode_hw(input logic [15:0] r);
      touch_cfg_pkg::hw_cfg_t h;
      h.noise_mode_static          = r[touch_cfg_pkg::HW_NOISE_STATIC_BIT];
      h.sample_cap_discharge_level = r[touch_cfg_pkg::HW_DISCHARGE_BIT];
      h.rf_filter_en               = r[touch_cfg_pkg::HW_RF_FILTER_BIT];
      h.pool_cap_large             = r[touch_cfg_pkg::HW_POOL_CAP_BIT];
      h.opamp_bias                 = r[11:10];
      h.count_limit                = count_limit_of(r[9:8]);
      // Top code bit disables; cycles still reported as zero then
      h.deep_sleep_autoprox_en     = ~r[7];
      h.deep_sleep_autoprox_cycles = r[7] ? 6'h00 : 6'(touch_cfg_pkg::AUTOPROX_BASE << r[6:5]);
      h.light_sleep_autoprox_en    = ~r[4];
      h.light_sleep_autoprox_cycles = r[4] ? 6'h00 : 6'(touch_cfg_pkg::AUTOPROX_BASE << r[3:2]);
      h.init_delay_cycles          = init_delay_of(r[1:0]);
      return h;
   endfunction

   // Host writes; unused bits masked so they never store
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lowpower_channel_setup        <= touch_cfg_pkg::RST_LP_SETUP;
         lowpower_channel_tx_select    <= touch_cfg_pkg::RST_LP_TX_SELECT;
         trackpad_conversion_frequency <= touch_cfg_pkg::RST_CONV_FREQ;
         lowpower_conversion_frequency <= touch_cfg_pkg::RST_CONV_FREQ;
         trackpad_hardware_settings    <= touch_cfg_pkg::RST_HW;
         lowpower_hardware_settings    <= touch_cfg_pkg::RST_HW;
         trackpad_settings             <= touch_cfg_pkg::RST_TP_SETTINGS;
      end else if (reg_write) begin
         if (reg_addr == touch_cfg_pkg::ADDR_LP_SETUP) begin
            lowpower_channel_setup <= reg_wdata & touch_cfg_pkg::MASK_LP_SETUP;
         end else if (reg_addr == touch_cfg_pkg::ADDR_LP_TX_SELECT) begin
            lowpower_channel_tx_select <= reg_wdata & touch_cfg_pkg::MASK_LP_TX_SELECT;
         end else if (reg_addr == touch_cfg_pkg::ADDR_TP_CONV_FREQ) begin
            trackpad_conversion_frequency <= reg_wdata & touch_cfg_pkg::MASK_CONV_FREQ;
         end else if (reg_addr == touch_cfg_pkg::ADDR_LP_CONV_FREQ) begin
            lowpower_conversion_frequency <= reg_wdata & touch_cfg_pkg::MASK_CONV_FREQ;
         end else if (reg_addr == touch_cfg_pkg::ADDR_TP_HW) begin
            trackpad_hardware_settings <= reg_wdata & touch_cfg_pkg::MASK_HW;
         end else if (reg_addr == touch_cfg_pkg::ADDR_LP_HW) begin
            lowpower_hardware_settings <= reg_wdata & touch_cfg_pkg::MASK_HW;
         end else if (reg_addr == touch_cfg_pkg::ADDR_TP_SETTINGS) begin
            trackpad_settings <= reg_wdata & touch_cfg_pkg::MASK_TP_SETTINGS;
         end
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      if (reg_addr == touch_cfg_pkg::ADDR_LP_SETUP) begin
         next_rdata = lowpower_channel_setup;
      end else if (reg_addr == touch_cfg_pkg::ADDR_LP_TX_SELECT) begin
         next_rdata = lowpower_channel_tx_select;
      end else if (reg_addr == touch_cfg_pkg::ADDR_TP_CONV_FREQ) begin
         next_rdata = trackpad_conversion_frequency;
      end else if (reg_addr == touch_cfg_pkg::ADDR_LP_CONV_FREQ) begin
         next_rdata = lowpower_conversion_frequency;
      end else if (reg_addr == touch_cfg_pkg::ADDR_TP_HW) begin
         next_rdata = trackpad_hardware_settings;
      end else if (reg_addr == touch_cfg_pkg::ADDR_LP_HW) begin
         next_rdata = lowpower_hardware_settings;
      end else if (reg_addr == touch_cfg_pkg::ADDR_TP_SETTINGS) begin
         next_rdata = trackpad_settings;
      end else begin
         next_rdata = 16'h0000;
      end
   end

   // Registered read answer, one cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // Decoded settings registered so the core sees glitch-free fields
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lowpower_cfg       <= '0;
         trackpad_conv_freq <= '0;
         lowpower_conv_freq <= '0;
         trackpad_hw_cfg    <= '0;
         lowpower_hw_cfg    <= '0;
         trackpad_cfg       <= '0;
      end else begin
         lowpower_cfg.count_filter_en <=
            lowpower_channel_setup[touch_cfg_pkg::LP_COUNT_FILTER_BIT];
         lowpower_cfg.sense_method <= touch_cfg_pkg::sense_method_t'(
            lowpower_channel_setup[touch_cfg_pkg::LP_SENSE_METHOD_BIT]);
         lowpower_cfg.rx_enable <= lowpower_channel_setup[7:0];
         lowpower_cfg.tx_enable <= lowpower_channel_tx_select[12:0];
         // Values are passed as stored; software computes them from the clock
         trackpad_conv_freq.fraction <= trackpad_conversion_frequency[15:8];
         trackpad_conv_freq.period   <= trackpad_conversion_frequency[7:0];
         lowpower_conv_freq.fraction <= lowpower_conversion_frequency[15:8];
         lowpower_conv_freq.period   <= lowpower_conversion_frequency[7:0];
         trackpad_hw_cfg <= decode_hw(trackpad_hardware_settings);
         lowpower_hw_cfg <= decode_hw(lowpower_hardware_settings);
         trackpad_cfg.total_rx              <= trackpad_settings[15:8];
         trackpad_cfg.moving_average_filter <= trackpad_settings[touch_cfg_pkg::TP_MAV_BIT];
         trackpad_cfg.fixed_damping_select  <=
            trackpad_settings[touch_cfg_pkg::TP_FIXED_DAMP_BIT];
         trackpad_cfg.iir_filter_en <= trackpad_settings[touch_cfg_pkg::TP_IIR_BIT];
         trackpad_cfg.axis_swap     <= trackpad_settings[touch_cfg_pkg::TP_SWAP_BIT];
         trackpad_cfg.flip_y        <= trackpad_settings[touch_cfg_pkg::TP_FLIP_Y_BIT];
         trackpad_cfg.flip_x        <= trackpad_settings[touch_cfg_pkg::TP_FLIP_X_BIT];
      end
   end

endmodule

// ==== touch_sensor_config_regs_props.sv ====
// Purpose: Port checks on the touch sensor configuration register bank
// Assumes: One clock, asynchronous active-high reset
// Notes:   Decode checks need one quiet cycle after the write they watch
`timescale 1ns/1ps
module touch_sensor_config_regs_props (
   input wire logic                          clock,
   input wire logic                          rst,
   input wire logic                          reg_write,
   input wire logic                          reg_read,
   input wire logic [7:0]                    reg_addr,
   input wire logic [15:0]                   reg_wdata,
   input wire logic [15:0]                   reg_rdata,
   input wire logic                          reg_rvalid,
   input wire touch_cfg_pkg::hw_cfg_t        trackpad_hw_cfg,
   input wire touch_cfg_pkg::hw_cfg_t        lowpower_hw_cfg,
   input wire touch_cfg_pkg::trackpad_cfg_t  trackpad_cfg
);
   logic [15:0] wdata_q1;
   logic [15:0] wdata_q2;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Write data two cycles back, matching the decode latency
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wdata_q1 <= 16'h0000;
         wdata_q2 <= 16'h0000;
      end else begin
         wdata_q1 <= reg_wdata;
         wdata_q2 <= wdata_q1;
      end
   end
   chk_read_answer_time: assert property (reg_read |=> reg_rvalid)
      else $error("read strobe not answered next cycle");
   chk_no_spurious_valid: assert property (reg_rvalid |-> $past(reg_read))
      else $error("read valid without a read strobe");
   // A slow host must still see the last answer
   chk_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   chk_setup_unused: assert property (reg_read && reg_addr == 8'h36 |=> reg_rdata[15:10] == 6'h00)
      else $error("setup unused bits not zero");
   chk_tx_unused: assert property (reg_read && reg_addr == 8'h37 |=> reg_rdata[15:13] == 3'h0)
      else $error("transmit unused bits not zero");
   chk_tp_unused: assert property (reg_read && reg_addr == 8'h41 |=> reg_rdata[7:6] == 2'h0)
      else $error("trackpad unused bits not zero");
   chk_unmapped_zero: assert property (reg_read && reg_addr > 8'h41 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_count_limit_top: assert property (reg_write && reg_addr == 8'h3F && reg_wdata[9:8] == 2'h3
      ##1 !reg_write |=> trackpad_hw_cfg.count_limit == 15'h4000)
      else $error("count limit code three wrong");
   chk_light_prox_off: assert property (reg_write && reg_addr == 8'h40 && reg_wdata[4]
      ##1 !reg_write |=> !lowpower_hw_cfg.light_sleep_autoprox_en)
      else $error("light sleep autoprox not disabled");
   chk_trackpad_follows: assert property (reg_write && reg_addr == 8'h41 ##1 !reg_write
      |=> trackpad_cfg == {wdata_q2[15:8], wdata_q2[5:0]})
      else $error("trackpad settings not decoded");
endmodule

bind touch_sensor_config_regs touch_sensor_config_regs_props chk (.clock(clock), .rst(rst),
   .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .trackpad_hw_cfg(trackpad_hw_cfg),
   .lowpower_hw_cfg(lowpower_hw_cfg), .trackpad_cfg(trackpad_cfg));

// ==== touch_sensor_config_regs_bench.sv ====
// Purpose: Self-checking bench for the touch sensor configuration register bank
// Assumes: Strobes driven by non-blocking assignment at the rising edge
// Notes:   Decoded outputs are sampled one edge after a write is taken
`timescale 1ns/1ps
module touch_sensor_config_regs_bench;
   logic                                 clock = 1'b0;
   logic                                 rst = 1'b1;
   logic                                 reg_write = 1'b0;
   logic                                 reg_read = 1'b0;
   logic [7:0]                           reg_addr = 8'h00;
   logic [15:0]                          reg_wdata = 16'h0000;
   logic [15:0]                          reg_rdata;
   logic                                 reg_rvalid;
   touch_cfg_pkg::lowpower_channel_cfg_t lowpower_cfg;
   touch_cfg_pkg::conv_freq_t            trackpad_conv_freq;
   touch_cfg_pkg::conv_freq_t            lowpower_conv_freq;
   touch_cfg_pkg::hw_cfg_t               trackpad_hw_cfg;
   touch_cfg_pkg::hw_cfg_t               lowpower_hw_cfg;
   touch_cfg_pkg::trackpad_cfg_t         trackpad_cfg;
   int                                   n_errors = 0;
   int                                   comparisons = 0;
   // Map with reset values and writable masks, in register order
   logic [7:0]  addrs [7] = '{8'h36, 8'h37, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41};
   logic [15:0] resets [7] = '{16'h0, 16'h0, 16'h7F01, 16'h7F01, 16'h0, 16'h0, 16'h0};
   logic [15:0] masks [7] = '{16'h03FF, 16'h1FFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFF3F};
   touch_sensor_config_regs dut (.clock(clock), .rst(rst), .reg_write(reg_write),
      .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .lowpower_cfg(lowpower_cfg), .trackpad_cfg(trackpad_cfg),
      .trackpad_conv_freq(trackpad_conv_freq), .lowpower_conv_freq(lowpower_conv_freq),
      .trackpad_hw_cfg(trackpad_hw_cfg), .lowpower_hw_cfg(lowpower_hw_cfg));
   always #4 clock = ~clock;
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Returns once the decoded outputs have taken the new value
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      check("read valid", 24'(reg_rvalid), 24'h1);
      d = reg_rdata;
   endtask
   task automatic t_freq;
      logic [7:0] per [6] = '{8'h01, 8'h05, 8'h0C, 8'h11, 8'h1A, 8'h35};
      @(posedge clock);
      #1;
      check("conv reset", 24'(trackpad_conv_freq), 24'h7F01);
      for (int i = 0; i < 6; i++) begin
         wr(i[0] ? 8'h3E : 8'h3D, {8'h7F, per[i]});
         check("conv freq", 24'(i[0] ? lowpower_conv_freq : trackpad_conv_freq),
            24'({8'h7F, per[i]}));
      end
      $display("end freq");
   endtask
   task automatic t_masks;
      logic [15:0] d;
      // Mid-run reset so the conversion registers written earlier show reset values again
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd(addrs[i], d);
         check("reset value", 24'(d), 24'(resets[i]));
         wr(addrs[i], 16'hFFFF);
         rd(addrs[i], d);
         check("ones readback", 24'(d), 24'(masks[i]));
      end
      wr(8'h50, 16'hFFFF);
      rd(8'h50, d);
      check("unmapped", 24'(d), 24'h0);
      $display("end masks");
   endtask
   task automatic t_channel;
      wr(8'h36, 16'hFEA5);
      check("count filter", 24'(lowpower_cfg.count_filter_en), 24'h1);
      check("rx enables", 24'(lowpower_cfg.rx_enable), 24'hA5);
      wr(8'h36, 16'h0155);
      check("sense method", 24'(lowpower_cfg[22:21]), 24'h1);
      wr(8'h37, 16'hF5A3);
      check("tx enables", 24'(lowpower_cfg.tx_enable), 24'h15A3);
      $display("end channel");
   endtask
   // Codes 4..7 on the light field and on the deep field turn autoprox off
   task automatic t_hw;
      touch_cfg_pkg::hw_cfg_t h;
      logic [14:0] lim [4] = '{15'h03FF, 15'h07FF, 15'h0FFF, 15'h4000};
      logic [6:0]  dly [4] = '{7'h04, 7'h10, 7'h20, 7'h40};
      for (int i = 0; i < 8; i++) begin
         wr(i[2] ? 8'h3F : 8'h40, {4'(i * 5), 2'(i), 2'(i), 3'(i), 3'(i ^ 4), 2'(i)});
         h = i[2] ? trackpad_hw_cfg : lowpower_hw_cfg;
         check("noise discharge", 24'({h.noise_mode_static, h.sample_cap_discharge_level}),
            24'(i * 5 / 4 % 4));
         check("rf and pool", 24'({h.rf_filter_en, h.pool_cap_large}), 24'(i * 5 % 4));
         check("opamp bias", 24'(h.opamp_bias), 24'(i % 4));
         check("count limit", 24'(h.count_limit), 24'(lim[i % 4]));
         check("deep prox", 24'({h.deep_sleep_autoprox_en, h.deep_sleep_autoprox_cycles}),
            i < 4 ? 24'(64 + (4 << i)) : 24'h0);
         check("light prox", 24'({h.light_sleep_autoprox_en, h.light_sleep_autoprox_cycles}),
            i > 3 ? 24'(64 + (4 << (i - 4))) : 24'h0);
         check("init delay", 24'(h.init_delay_cycles), 24'(dly[i % 4]));
      end
      $display("end hw");
   endtask
   task automatic t_trackpad;
      for (int b = 0; b < 6; b++) begin
         wr(8'h41, 16'h09C0 | (16'h0001 << b));
         check("trackpad", 24'(trackpad_cfg), 24'({8'h09, 6'(1 << b)}));
      end
      $display("end trackpad");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_freq;
      t_masks;
      t_channel;
      t_hw;
      t_trackpad;
      results;
   end
   // The tests need well under two thousand cycles
   initial begin
      #20000;
      n_errors++;
      results;
   end
endmodule
